// >>> rtl/ecq_top.sv
// error code store and auxiliary position query engine
// assumes commands and status come from logic on clk_sys; encoder pins
// are asynchronous and synchronised inside each axis counter
`timescale 1ns/1ps

module ecq_top (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  // command port
  input  wire logic                         cmd_valid,
  input  wire ecq_pkg::ecq_cmd_type         cmd,
  output logic                              cmd_ready,
  output logic                              cmd_reject,
  // answer port
  output logic                              resp_valid,
  output logic [ecq_pkg::CNT_W-1:0]         resp_data,
  output logic                              resp_last,
  // error events and stored code
  input  wire ecq_pkg::ecq_event_type       evt,
  output logic [ecq_pkg::CODE_W-1:0]        err_code,
  // axis state
  input  wire logic [ecq_pkg::NUM_AXES-1:0] motor_off_state,
  input  wire logic [ecq_pkg::NUM_AXES-1:0] stepper_mode,
  input  wire logic [ecq_pkg::NUM_AXES-1:0] electronic_cam_mode,
  input  wire logic [ecq_pkg::NUM_AXES-1:0] compare_in_use,
  input  wire logic [2*ecq_pkg::NUM_AXES-1:0] enc_type,
  // encoder pins and step strobes
  input  wire logic [ecq_pkg::NUM_AXES-1:0] aux_enc_a,
  input  wire logic [ecq_pkg::NUM_AXES-1:0] aux_enc_b,
  input  wire logic [ecq_pkg::NUM_AXES-1:0] step_pulse,
  input  wire logic [ecq_pkg::NUM_AXES-1:0] step_dir,
  // auxiliary counting offered per axis
  output logic [ecq_pkg::NUM_AXES-1:0]      aux_enc_avail
);

  typedef enum logic {ST_IDLE, ST_AUX} ecq_state_type;

  localparam int NA = ecq_pkg::NUM_AXES;
  localparam int CW = ecq_pkg::CNT_W;

  ecq_state_type              state_q;
  logic                       ready_q;
  logic                       reject_q;
  logic                       rvalid_q;
  logic [CW-1:0]              rdata_q;
  logic                       rlast_q;
  logic [ecq_pkg::CODE_W-1:0] err_q;
  logic [ecq_pkg::CODE_W-1:0] err_d;
  logic [NA-1:0]              avail_q;
  logic [NA-1:0]              mask_q;
  logic [1:0]                 idx_q;
  logic [CW-1:0]              counts [NA];
  logic                       take;
  logic                       take_other;
  logic                       rej_now;
  logic [ecq_pkg::CODE_W-1:0] rej_code;
  logic                       evt_any;
  logic [ecq_pkg::CODE_W-1:0] evt_code;
  logic                       new_err;
  logic                       axis_off;
  logic                       axis_step;
  logic                       axis_cam;
  logic [1:0]                 axis_enc;
  logic [NA-1:0]              mask_in;
  logic [NA-1:0]              higher;

  // ----------------------------------------------------------------
  // per axis counters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NA; g++) begin : g_axis
    ecq_aux_counter u_cnt (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .stepper_mode   (stepper_mode[g]),
      .compare_in_use (compare_in_use[g]),
      .aux_enc_a      (aux_enc_a[g]),
      .aux_enc_b      (aux_enc_b[g]),
      .step_pulse     (step_pulse[g]),
      .step_dir       (step_dir[g]),
      .count          (counts[g])
    );
  end

  // ----------------------------------------------------------------
  // command checks
  // ----------------------------------------------------------------
  assign take       = cmd_valid && ready_q;
  assign take_other = take && cmd.op == ecq_pkg::OP_OTHER;
  assign axis_off   = motor_off_state[cmd.axis];
  assign axis_step  = stepper_mode[cmd.axis];
  assign axis_cam   = electronic_cam_mode[cmd.axis];
  assign axis_enc   = enc_type[2*cmd.axis +: 2];

  // first failing condition names the rejection
  always_comb begin
    rej_now  = 1'b1;
    rej_code = ecq_pkg::ERR_NONE;
    if (cmd.need_all_off && !(&motor_off_state)) begin
      rej_code = ecq_pkg::ERR_ALL_MOTORS_ON;
    end else if (cmd.need_axis_off && !axis_off) begin
      rej_code = ecq_pkg::ERR_MOTOR_ON;
    end else if (cmd.no_stepper && axis_step) begin
      rej_code = ecq_pkg::ERR_STEPPER_AXIS;
    end else if (cmd.no_cam && axis_cam) begin
      rej_code = ecq_pkg::ERR_CAM_MODE;
    end else if (cmd.enc_check && axis_enc != cmd.enc_type) begin
      rej_code = ecq_pkg::ERR_ENC_TYPE;
    end else begin
      rej_now = 1'b0;
    end
    rej_now = rej_now && take_other;
  end

  // ----------------------------------------------------------------
  // event codes; one event per cycle expected, fixed order otherwise
  // ----------------------------------------------------------------
  always_comb begin
    evt_any  = 1'b1;
    evt_code = ecq_pkg::ERR_NONE;
    if (evt.lock_reject) begin
      evt_code = ecq_pkg::ERR_LOCKED;
    end else if (evt.bad_password) begin
      evt_code = ecq_pkg::ERR_BAD_PASSWORD;
    end else if (evt.password_mismatch) begin
      evt_code = ecq_pkg::ERR_PASS_MISMATCH;
    end else if (evt.serial_timeout) begin
      evt_code = ecq_pkg::ERR_SERIAL_TMO;
    end else if (evt.bz_timeout) begin
      evt_code = ecq_pkg::ERR_BZ_TIMEOUT;
    end else if (evt.bz_no_motion) begin
      evt_code = ecq_pkg::ERR_BZ_NO_MOTION;
    end else if (evt.bz_runaway) begin
      evt_code = ecq_pkg::ERR_BZ_RUNAWAY;
    end else if (evt.net_tx_fail) begin
      evt_code = ecq_pkg::ERR_NET_TX;
    end else if (evt.net_bad_packet) begin
      evt_code = ecq_pkg::ERR_NET_RX_PACKET;
    end else if (evt.tcp_lost_sync) begin
      evt_code = ecq_pkg::ERR_TCP_SYNC;
    end else begin
      evt_any = 1'b0;
    end
  end

  // the command's own rejection is reported over a side event
  assign new_err = rej_now || evt_any;
  assign err_d   = rej_now ? rej_code : evt_code;

  // ----------------------------------------------------------------
  // stored error code; a new error wins over the query's clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      err_q <= ecq_pkg::ERR_NONE;
    end else if (new_err) begin
      err_q <= err_d;
    end else if (take && cmd.op == ecq_pkg::OP_ERR_QUERY) begin
      err_q <= ecq_pkg::ERR_NONE;
    end
  end

  // ----------------------------------------------------------------
  // availability of auxiliary counting
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avail_q <= '0;
    end else begin
      avail_q <= ~stepper_mode & ~compare_in_use;
    end
  end

  // ----------------------------------------------------------------
  // query sequencer; aux answers one word per selected axis
  // ----------------------------------------------------------------
  // a zero mask means every axis, as an empty argument does
  assign mask_in = (cmd.arg[NA-1:0] == '0) ? '1 : cmd.arg[NA-1:0];
  // 3-bit sum so that index 3 shifts the whole mask out and ends the walk
  assign higher  = mask_q >> ({1'b0, idx_q} + 3'h1);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q  <= ST_IDLE;
      ready_q  <= 1'b0;
      reject_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rlast_q  <= 1'b0;
      mask_q   <= '0;
      idx_q    <= 2'h0;
    end else begin
      reject_q <= rej_now;
      rvalid_q <= 1'b0;
      rlast_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ready_q <= 1'b1;
          if (take) begin
            case (cmd.op)
              ecq_pkg::OP_ERR_QUERY,
              ecq_pkg::OP_ERR_OPERAND: begin
                // every argument form reads the same code
                rvalid_q <= 1'b1;
                rdata_q  <= {{(CW-ecq_pkg::CODE_W){1'b0}}, err_q};
                rlast_q  <= 1'b1;
              end
              ecq_pkg::OP_AUX_QUERY: begin
                mask_q  <= mask_in;
                idx_q   <= 2'h0;
                ready_q <= 1'b0;
                state_q <= ST_AUX;
              end
              default: begin
                rvalid_q <= 1'b0;
              end
            endcase
          end
        end
        ST_AUX: begin
          if (mask_q[idx_q]) begin
            rvalid_q <= 1'b1;
            rdata_q  <= counts[idx_q];
            rlast_q  <= (higher == '0);
          end
          if (higher == '0) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
          end
          idx_q <= idx_q + 2'h1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready     = ready_q;
  assign cmd_reject    = reject_q;
  assign resp_valid    = rvalid_q;
  assign resp_data     = rdata_q;
  assign resp_last     = rlast_q;
  assign err_code      = err_q;
  assign aux_enc_avail = avail_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic only_evt;
  assign only_evt = $onehot(evt) && !take_other;

  property p_query_reads;
    @(posedge clk_sys) disable iff (sys_rst)
    take && cmd.op == ecq_pkg::OP_ERR_QUERY
      |=> resp_valid && resp_last && resp_data[7:0] == $past(err_q);
  endproperty
  a_query_reads: assert property (p_query_reads)
    else $error("query did not return stored code");

  property p_query_clears;
    @(posedge clk_sys) disable iff (sys_rst)
    take && cmd.op == ecq_pkg::OP_ERR_QUERY && !new_err
      |=> err_code == ecq_pkg::ERR_NONE;
  endproperty
  a_query_clears: assert property (p_query_clears)
    else $error("query left code uncleared");

  property p_operand_keeps;
    @(posedge clk_sys) disable iff (sys_rst)
    take && cmd.op == ecq_pkg::OP_ERR_OPERAND && !new_err
      |=> $stable(err_code) && resp_data[7:0] == err_code;
  endproperty
  a_operand_keeps: assert property (p_operand_keeps)
    else $error("operand read changed code");

  property p_serial_code;
    @(posedge clk_sys) disable iff (sys_rst)
    only_evt && evt.serial_timeout |=> err_code == ecq_pkg::ERR_SERIAL_TMO;
  endproperty
  a_serial_code: assert property (p_serial_code)
    else $error("serial timeout code wrong");

  property p_aux_first;
    @(posedge clk_sys) disable iff (sys_rst)
    take && cmd.op == ecq_pkg::OP_AUX_QUERY && cmd.arg[0]
      |=> ##1 resp_valid && resp_data == $past(counts[0]);
  endproperty
  a_aux_first: assert property (p_aux_first)
    else $error("aux answer not first axis count");

  property p_bz_codes;
    @(posedge clk_sys) disable iff (sys_rst)
    only_evt && evt.bz_runaway |=> err_code == ecq_pkg::ERR_BZ_RUNAWAY;
  endproperty
  a_bz_codes: assert property (p_bz_codes)
    else $error("zeroing runaway code wrong");

  property p_net_codes;
    @(posedge clk_sys) disable iff (sys_rst)
    only_evt && evt.tcp_lost_sync |=> err_code == ecq_pkg::ERR_TCP_SYNC;
  endproperty
  a_net_codes: assert property (p_net_codes)
    else $error("sync loss code wrong");

  property p_lock_code;
    @(posedge clk_sys) disable iff (sys_rst)
    only_evt && evt.lock_reject |=> err_code == ecq_pkg::ERR_LOCKED;
  endproperty
  a_lock_code: assert property (p_lock_code)
    else $error("locked code wrong");

  property p_all_off;
    @(posedge clk_sys) disable iff (sys_rst)
    take_other && cmd.need_all_off && !(&motor_off_state)
      |=> cmd_reject && err_code == ecq_pkg::ERR_ALL_MOTORS_ON;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("all-off rejection missing");

  property p_newest;
    @(posedge clk_sys) disable iff (sys_rst)
    new_err |=> err_code == $past(err_d);
  endproperty
  a_newest: assert property (p_newest)
    else $error("newer error not stored");

  c_query:  cover property (@(posedge clk_sys)
    take && cmd.op == ecq_pkg::OP_ERR_QUERY && err_q != '0);
  c_aux:    cover property (@(posedge clk_sys) resp_valid && !resp_last);
  c_reject: cover property (@(posedge clk_sys) cmd_reject);

endmodule

// >>> rtl/ecq_pkg.sv
// package for the error code and auxiliary position query block
// assumes one 50 MHz clock domain and a synchronous active-high reset
package ecq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_AXES = 4;
  localparam int CNT_W    = 32;
  localparam int CODE_W   = 8;
  localparam int ARG_W    = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] ERR_NONE = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000;
  localparam logic [ARG_W-1:0]  ARG_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // error codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] ERR_CAM_MODE      = 8'h68; // 104
  localparam logic [CODE_W-1:0] ERR_BZ_TIMEOUT    = 8'h70; // 112
  localparam logic [CODE_W-1:0] ERR_BZ_NO_MOTION  = 8'h71; // 113
  localparam logic [CODE_W-1:0] ERR_BZ_RUNAWAY    = 8'h72; // 114
  localparam logic [CODE_W-1:0] ERR_STEPPER_AXIS  = 8'h77; // 119
  localparam logic [CODE_W-1:0] ERR_NET_TX        = 8'h78; // 120
  localparam logic [CODE_W-1:0] ERR_NET_RX_PACKET = 8'h79; // 121
  localparam logic [CODE_W-1:0] ERR_TCP_SYNC      = 8'h7B; // 123
  localparam logic [CODE_W-1:0] ERR_SERIAL_TMO    = 8'h83; // 131
  localparam logic [CODE_W-1:0] ERR_LOCKED        = 8'h85; // 133
  localparam logic [CODE_W-1:0] ERR_ALL_MOTORS_ON = 8'h86; // 134
  localparam logic [CODE_W-1:0] ERR_MOTOR_ON      = 8'h87; // 135
  localparam logic [CODE_W-1:0] ERR_BAD_PASSWORD  = 8'h88; // 136
  localparam logic [CODE_W-1:0] ERR_PASS_MISMATCH = 8'h8A; // 138
  localparam logic [CODE_W-1:0] ERR_ENC_TYPE      = 8'h90; // 144

  // ----------------------------------------------------------------
  // command carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_ERR_QUERY,   // error_code_query, any of its three forms
    OP_ERR_OPERAND, // error_code_operand read
    OP_AUX_QUERY,   // aux_position_query with axis mask
    OP_OTHER        // any other command, checked for rejection
  } ecq_op_type;

  typedef struct packed {
    ecq_op_type       op;
    logic [ARG_W-1:0] arg;          // query argument or axis mask
    logic [1:0]       axis;         // addressed axis of an other command
    logic             need_all_off; // needs every motor off
    logic             need_axis_off;// needs addressed motor off
    logic             no_stepper;   // not allowed on stepper axis
    logic             no_cam;       // not allowed in cam mode
    logic             enc_check;    // depends on encoder type
    logic [1:0]       enc_type;     // encoder type it expects
  } ecq_cmd_type;

  // one-cycle error event strobes from the rest of the controller
  typedef struct packed {
    logic serial_timeout;
    logic bz_timeout;
    logic bz_no_motion;
    logic bz_runaway;
    logic net_tx_fail;
    logic net_bad_packet;
    logic tcp_lost_sync;
    logic lock_reject;
    logic bad_password;
    logic password_mismatch;
  } ecq_event_type;

endpackage

// >>> rtl/ecq_aux_counter.sv
// one axis of auxiliary position counting
// assumes encoder pins are asynchronous and step strobes are on clk_sys
`timescale 1ns/1ps

module ecq_aux_counter (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // axis configuration
  input  wire logic                      stepper_mode,
  input  wire logic                      compare_in_use,
  // encoder pins
  input  wire logic                      aux_enc_a,
  input  wire logic                      aux_enc_b,
  // step generator strobes
  input  wire logic                      step_pulse,
  input  wire logic                      step_dir,
  // count
  output logic [ecq_pkg::CNT_W-1:0]      count
);

  logic [1:0]                 sync1_q;
  logic [1:0]                 sync2_q;
  logic [1:0]                 prev_q;
  logic [ecq_pkg::CNT_W-1:0]  cnt_q;
  logic                       enc_on;
  logic                       up;
  logic                       dn;

  // ----------------------------------------------------------------
  // pin synchroniser, first stage read only by second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q  <= 2'h0;
    end else begin
      sync1_q <= {aux_enc_a, aux_enc_b};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // quadrature decode, one count per gray step
  assign enc_on = !stepper_mode && !compare_in_use;
  assign up = (prev_q == 2'h0 && sync2_q == 2'h2) ||
              (prev_q == 2'h2 && sync2_q == 2'h3) ||
              (prev_q == 2'h3 && sync2_q == 2'h1) ||
              (prev_q == 2'h1 && sync2_q == 2'h0);
  assign dn = (prev_q == 2'h0 && sync2_q == 2'h1) ||
              (prev_q == 2'h1 && sync2_q == 2'h3) ||
              (prev_q == 2'h3 && sync2_q == 2'h2) ||
              (prev_q == 2'h2 && sync2_q == 2'h0);

  // ----------------------------------------------------------------
  // counter: steps on a stepper axis, encoder otherwise while compare is not in use
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= ecq_pkg::CNT_RST;
    end else if (stepper_mode) begin
      if (step_pulse) begin
        cnt_q <= step_dir ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end else if (enc_on && up) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (enc_on && dn) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign count = cnt_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_step_count;
    @(posedge clk_sys) disable iff (sys_rst)
    stepper_mode && step_pulse && step_dir
      |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_step_count: assert property (p_step_count)
    else $error("step count did not advance");

  property p_no_enc_count;
    @(posedge clk_sys) disable iff (sys_rst)
    !stepper_mode && compare_in_use |=> $stable(cnt_q);
  endproperty
  a_no_enc_count: assert property (p_no_enc_count)
    else $error("encoder counted while compare in use");

  c_enc_up: cover property (@(posedge clk_sys) enc_on && up);

endmodule

// >>> dv/ecq_enc_model.sv
// quadrature source standing in for one auxiliary encoder
// assumes move is driven on clk_sys; the block reads the pins as async
`timescale 1ns/1ps

module ecq_enc_model (
  // clock
  input  wire logic clk_sys,
  // one quarter step per cycle while high
  input  wire logic move,
  // encoder pins
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] ph_q = 2'h0;

  // phase advance; gray coding keeps one pin changing per step
  always_ff @(posedge clk_sys) begin
    if (move) begin
      ph_q <= ph_q + 2'h1;
    end
  end
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
endmodule

// >>> dv/testbench.sv
// self-checking bench for the error code and aux position block
// assumes ecq_pkg is compiled first; one 50 MHz clock
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                  clk_sys, sys_rst, cmd_valid, mv;
  ecq_pkg::ecq_cmd_type  cmd;
  ecq_pkg::ecq_event_type evt;
  logic                  cmd_ready, cmd_reject, resp_valid, resp_last;
  logic [31:0]           resp_data;
  logic [7:0]            err_code;
  logic [3:0]            sp, sd, avail;
  wire logic [3:0]       aux_a, aux_b;
  logic [33:0]           exp_q[$];
  logic [33:0]           w;
  int                    err_total, n_checks, seed, exp_code, i, k, s, t;
  int codes[10] = '{131, 112, 113, 114, 120, 121, 123, 133, 136, 138};
  logic [4:0] rf[6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h0B};
  logic [1:0] ra[6] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0] re[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0};
  int rc[6] = '{134, 135, 119, 104, 144, 0};

  ecq_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
    .evt(evt), .err_code(err_code), .motor_off_state(4'h5),
    .stepper_mode(4'h2), .electronic_cam_mode(4'h8),
    .compare_in_use(4'h4), .enc_type(8'hE4), .aux_enc_a(aux_a),
    .aux_enc_b(aux_b), .step_pulse(sp), .step_dir(sd),
    .aux_enc_avail(avail));
  // axis 1 is a stepper, so its encoder motion must not show
  ecq_enc_model u_enc0 (.clk_sys(clk_sys), .move(mv), .enc_a(aux_a[0]),
    .enc_b(aux_b[0]));
  ecq_enc_model u_enc1 (.clk_sys(clk_sys), .move(mv), .enc_a(aux_a[1]),
    .enc_b(aux_b[1]));
  assign aux_a[3:2] = 2'h0;
  assign aux_b[3:2] = 2'h0;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic ecq_pkg::ecq_cmd_type mk(ecq_pkg::ecq_op_type op,
    logic [7:0] arg, logic [1:0] ax, logic [4:0] fl, logic [1:0] et);
    mk = {op, arg, ax, fl, et};
  endfunction

  // hold the request until an edge sees ready
  task automatic issue(input ecq_pkg::ecq_cmd_type c);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd <= c;
    cmd_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 60);
    cmd_valid <= 1'b0;
    if (n >= 60) begin
      err_total++;
      give_verdict();
    end
  endtask

  // one-cycle event strobe, newest code must win
  task automatic fire(input int j);
    @(posedge clk_sys);
    evt <= ecq_pkg::ecq_event_type'(10'h200 >> j);
    @(posedge clk_sys);
    evt <= '0;
    exp_code = codes[j];
    @(negedge clk_sys);
    chk8(err_code, exp_code[7:0]);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 60) begin
      err_total++;
      give_verdict();
    end
  endtask

  // answers checked mid-cycle; encoder count direction is free
  always @(negedge clk_sys) begin
    if (resp_valid === 1'b1) begin
      // an answer nobody expects can never match its own inverse
      w = (exp_q.size() != 0) ? exp_q.pop_front() : {2'b00, ~resp_data};
      if (w[33] && resp_data === -w[31:0]) begin
        w[31:0] = resp_data;
      end
      chk32(resp_data, w[31:0]);
      chk8({7'h0, resp_last}, {7'h0, w[32]});
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    evt = '0;
    sp = 4'h0;
    sd = 4'hF;
    mv = 1'b0;
    err_total = 0;
    n_checks = 0;
    seed = 68;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk8({4'h0, avail}, 8'h09);
    for (i = 0; i < 10; i++) begin
      fire(i);
    end
    exp_q.push_back({2'b01, 32'(exp_code)});
    issue(mk(ecq_pkg::OP_ERR_OPERAND, 8'h00, 2'h0, 5'h00, 2'h0));
    drain();
    chk8(err_code, exp_code[7:0]);
    // the three query forms all answer and clear
    for (i = 0; i < 3; i++) begin
      fire(i);
      exp_q.push_back({2'b01, 32'(exp_code)});
      k = (i == 2) ? $random(seed) : ((i == 1) ? 8'h3F : 8'h00);
      issue(mk(ecq_pkg::OP_ERR_QUERY, k[7:0], 2'h0, 5'h00, 2'h0));
      drain();
      chk8(err_code, 8'h00);
    end
    for (i = 0; i < 6; i++) begin
      issue(mk(ecq_pkg::OP_OTHER, 8'h00, ra[i], rf[i], re[i]));
      s = 0;
      repeat (3) @(negedge clk_sys) if (cmd_reject === 1'b1) s = 1;
      chk8(8'(s), 8'(rc[i] != 0));
      if (rc[i] != 0) exp_code = rc[i];
      chk8(err_code, exp_code[7:0]);
    end
    k = ($random(seed) & 15) + 2;
    s = ($random(seed) & 15) + 1;
    @(posedge clk_sys);
    mv <= 1'b1;
    repeat (k) @(posedge clk_sys);
    mv <= 1'b0;
    // random step direction per pulse, net count kept as an integer
    t = 0;
    repeat (s) begin
      @(posedge clk_sys);
      i = $random(seed);
      sp <= 4'h2;
      sd <= {2'h3, i[0], 1'b1};
      t = i[0] ? t + 1 : t - 1;
      @(posedge clk_sys);
      sp <= 4'h0;
    end
    repeat (6) @(posedge clk_sys);
    exp_q.push_back({2'b10, 32'(k)});
    exp_q.push_back({2'b01, 32'(t)});
    issue(mk(ecq_pkg::OP_AUX_QUERY, 8'h03, 2'h0, 5'h00, 2'h0));
    exp_q.push_back({2'b10, 32'(k)});
    exp_q.push_back({2'b00, 32'(t)});
    exp_q.push_back({2'b00, 32'h0});
    exp_q.push_back({2'b01, 32'h0});
    issue(mk(ecq_pkg::OP_AUX_QUERY, 8'hF0, 2'h0, 5'h00, 2'h0));
    exp_q.push_back({2'b01, 32'(exp_code)});
    exp_q.push_back({2'b01, 32'h0});
    issue(mk(ecq_pkg::OP_ERR_QUERY, 8'h00, 2'h0, 5'h00, 2'h0));
    issue(mk(ecq_pkg::OP_ERR_QUERY, 8'h00, 2'h0, 5'h00, 2'h0));
    drain();
    give_verdict();
  end
endmodule
